// *** rtl/opc_pkg.sv ***
// Function
// - The channel-1 format field in bits 6 to 5 selects disabled, AC differential, HCSL or LVCMOS for codes 0 to 3 and resets to 1.
// - The channel-1 mode A field in bits 4 to 3 resets to 2 and sets the tail current to 4, 6, 8 or 16 mA, or in LVCMOS the positive pin to tristate, low, inverted or true.
// - The channel-1 mode B field in bits 2 to 1 resets to 0 and sets the HCSL load to tristate, 50, 100 or 200 ohm, or in LVCMOS the negative pin likewise.
// - The shared 8-bit divider code 0 bypasses and any other code N divides by N plus 1.
// - One divider value serves channels 0 and 1 together and resets to 1, a ratio of two.
// - The source select routes the first PLL to the shared divider when 0 and the second when 1, and resets to 1.
package opc_pkg;
  // ==========================================================
  // Bus and register map
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int REG_DW = 8;
  localparam logic [7:0] IDX_SRC = 8'h1F;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_DIV = 8'h21;
  localparam logic [7:0] IDX_STAT = 8'h22;
  localparam logic [APB_AW-1:0] ADDR_SRC = {2'h0, IDX_SRC, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
  // ==========================================================
  // Fields and reset values
  localparam int FMT_HI = 6;
  localparam int FMT_LO = 5;
  localparam int MA_HI = 4;
  localparam int MA_LO = 3;
  localparam int MB_HI = 2;
  localparam int MB_LO = 1;
  localparam int SRC_BIT = 7;
  localparam logic [REG_DW-1:0] CTRL_MASK = 8'h7E;
  localparam logic [REG_DW-1:0] CTRL_RST = 8'h30;
  localparam logic [REG_DW-1:0] DIV_RST = 8'h01;
  localparam logic [REG_DW-1:0] DIV_BYPASS = 8'h00;
  localparam logic [REG_DW-1:0] CNT_ONE = 8'h01;
  localparam logic SRC_RST = 1'b1;
  // ==========================================================
  // Decoded driver settings
  localparam logic [4:0] TAIL_MA_0 = 5'h04;
  localparam logic [4:0] TAIL_MA_1 = 5'h06;
  localparam logic [4:0] TAIL_MA_2 = 5'h08;
  localparam logic [4:0] TAIL_MA_3 = 5'h10;
  localparam logic [7:0] LOAD_OHM_0 = 8'h00;
  localparam logic [7:0] LOAD_OHM_1 = 8'h32;
  localparam logic [7:0] LOAD_OHM_2 = 8'h64;
  localparam logic [7:0] LOAD_OHM_3 = 8'hC8;
  // Pin code is {drive enable, powered, inverted}
  localparam logic [2:0] PIN_TRI = 3'h0;
  localparam logic [2:0] PIN_LOW = 3'h4;
  localparam logic [2:0] PIN_INV = 3'h7;
  localparam logic [2:0] PIN_TRUE = 3'h6;

  typedef enum logic [1:0] {
    FMT_OFF = 2'h0,
    FMT_DIFF = 2'h1,
    FMT_HCSL = 2'h2,
    FMT_CMOS = 2'h3
  } opc_fmt_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'h1,
    APB_ACCESS = 2'h2
  } opc_apb_state_type;

  function automatic logic [4:0] f_tail_ma(input logic [1:0] code);
    case (code)
      2'h0: f_tail_ma = TAIL_MA_0;
      2'h1: f_tail_ma = TAIL_MA_1;
      2'h2: f_tail_ma = TAIL_MA_2;
      default: f_tail_ma = TAIL_MA_3;
    endcase
  endfunction

  function automatic logic [7:0] f_load_ohm(input logic [1:0] code);
    case (code)
      2'h0: f_load_ohm = LOAD_OHM_0;
      2'h1: f_load_ohm = LOAD_OHM_1;
      2'h2: f_load_ohm = LOAD_OHM_2;
      default: f_load_ohm = LOAD_OHM_3;
    endcase
  endfunction

  function automatic logic [2:0] f_pin(input logic [1:0] code);
    case (code)
      2'h0: f_pin = PIN_TRI;
      2'h1: f_pin = PIN_LOW;
      2'h2: f_pin = PIN_INV;
      default: f_pin = PIN_TRUE;
    endcase
  endfunction
endpackage

// *** rtl/opc_drv_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module opc_drv_decode
  import opc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [1:0] fmt_i,
  input wire logic [1:0] mode_a_i,
  input wire logic [1:0] mode_b_i,
  output logic diff_en_o,
  output logic hcsl_en_o,
  output logic cmos_en_o,
  output logic [4:0] tail_ma_o,
  output logic [7:0] load_ohm_o,
  output logic [2:0] pin_p_o,
  output logic [2:0] pin_n_o
);
  logic [21:0] out_d;
  logic [21:0] out_q;
  logic is_diff;
  logic is_hcsl;
  logic is_cmos;

  // ==========================================================
  // Format and mode decode
  always_comb begin
    is_diff = (fmt_i == FMT_DIFF);
    is_hcsl = (fmt_i == FMT_HCSL);
    is_cmos = (fmt_i == FMT_CMOS);
    out_d = {is_diff, is_hcsl, is_cmos,
             (is_diff || is_hcsl) ? f_tail_ma(mode_a_i) : 5'h00,
             is_hcsl ? f_load_ohm(mode_b_i) : LOAD_OHM_0,
             is_cmos ? f_pin(mode_a_i) : PIN_TRI,
             is_cmos ? f_pin(mode_b_i) : PIN_TRI};
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign {diff_en_o, hcsl_en_o, cmos_en_o, tail_ma_o, load_ohm_o, pin_p_o, pin_n_o} = out_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  property p_fmt_off;
    fmt_i == FMT_OFF |=> !diff_en_o && !hcsl_en_o && !cmos_en_o && pin_p_o == PIN_TRI;
  endproperty
  a_fmt_off: assert property (p_fmt_off) else $error("disabled format still drives");

  property p_tail;
    fmt_i == FMT_DIFF && mode_a_i == 2'h3 |=> tail_ma_o == TAIL_MA_3 && diff_en_o;
  endproperty
  a_tail: assert property (p_tail) else $error("tail current wrong");

  property p_load;
    fmt_i == FMT_HCSL && mode_b_i == 2'h1 |=> load_ohm_o == LOAD_OHM_1 && hcsl_en_o;
  endproperty
  a_load: assert property (p_load) else $error("hcsl load wrong");

  property p_cmos_pins;
    fmt_i == FMT_CMOS |=> pin_p_o == f_pin($past(mode_a_i)) && pin_n_o == f_pin($past(mode_b_i));
  endproperty
  a_cmos_pins: assert property (p_cmos_pins) else $error("cmos pin mode wrong");
endmodule // opc_drv_decode
`default_nettype wire

// *** rtl/opc_divider.sv ***
`timescale 1ns/1ns
`default_nettype none
module opc_divider
  import opc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic [REG_DW-1:0] div_i,
  output logic tick_o,
  output logic [REG_DW-1:0] count_o
);
  logic [REG_DW-1:0] cnt_d;
  logic [REG_DW-1:0] cnt_q;
  logic tick_d;
  logic tick_q;

  // ==========================================================
  // Divide by code plus one, code zero passes through
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (div_i == DIV_BYPASS) begin
      cnt_d = '0;
      tick_d = tick_i;
    end else if (tick_i) begin
      if (cnt_q >= div_i) begin
        cnt_d = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
  assign count_o = cnt_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  property p_bypass;
    div_i == DIV_BYPASS |=> tick_o == $past(tick_i);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not pass input");

  property p_wrap;
    div_i != DIV_BYPASS && tick_i && cnt_q == div_i |=> tick_o && cnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("divider missed its output");

  property p_step;
    div_i != DIV_BYPASS && tick_i && cnt_q < div_i |=> !tick_o && cnt_q == $past(cnt_q) + CNT_ONE;
  endproperty
  a_step: assert property (p_step) else $error("divider counted wrong");

  property p_quiet;
    !tick_i |=> !tick_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output without input");
endmodule // opc_divider
`default_nettype wire

// *** rtl/opc_output_pair_regs.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module opc_output_pair_regs
  import opc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [APB_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pll1_tick_i,
  input wire logic pll2_tick_i,
  output logic ch0_div_tick_o,
  output logic ch1_div_tick_o,
  output logic ch01_pll_source_select_o,
  output logic [1:0] ch1_format_o,
  output logic ch1_diff_en_o,
  output logic ch1_hcsl_en_o,
  output logic ch1_cmos_en_o,
  output logic [4:0] ch1_tail_ma_o,
  output logic [7:0] ch1_load_ohm_o,
  output logic ch1_p_oe_o,
  output logic ch1_p_active_o,
  output logic ch1_p_inv_o,
  output logic ch1_n_oe_o,
  output logic ch1_n_active_o,
  output logic ch1_n_inv_o
);
  opc_apb_state_type state_d;
  opc_apb_state_type state_q;
  logic [REG_DW-1:0] ctrl_d;
  logic [REG_DW-1:0] ctrl_q;
  logic [REG_DW-1:0] div_d;
  logic [REG_DW-1:0] div_q;
  logic src_d;
  logic src_q;
  logic [REG_DW-1:0] rdata_d;
  logic [REG_DW-1:0] rdata_q;
  logic slverr_d;
  logic slverr_q;
  logic [REG_DW-1:0] wdata8;
  logic addr_hit;
  logic setup_cyc;
  logic access_cyc;
  logic wr_en;
  logic sel_tick;
  logic [REG_DW-1:0] div_count;
  logic div_tick;
  logic [2:0] pin_p;
  logic [2:0] pin_n;

  // ==========================================================
  // Address decode
  function automatic logic f_hit(input logic [APB_AW-1:0] a);
    f_hit = (a == ADDR_SRC) || (a == ADDR_CTRL) || (a == ADDR_DIV) || (a == ADDR_STAT);
  endfunction

  function automatic logic [REG_DW-1:0] f_read(input logic [APB_AW-1:0] a,
                                               input logic [REG_DW-1:0] ctrl,
                                               input logic [REG_DW-1:0] div,
                                               input logic src,
                                               input logic [REG_DW-1:0] cnt);
    f_read = '0;
    if (a == ADDR_SRC) begin
      f_read[SRC_BIT] = src;
    end else if (a == ADDR_CTRL) begin
      f_read = ctrl & CTRL_MASK;
    end else if (a == ADDR_DIV) begin
      f_read = div;
    end else if (a == ADDR_STAT) begin
      f_read = cnt;
    end
  endfunction

  assign wdata8 = pwdata_i[REG_DW-1:0];
  assign addr_hit = f_hit(paddr_i);
  assign setup_cyc = psel_i && !penable_i;
  assign access_cyc = psel_i && penable_i && (state_q == APB_ACCESS);
  assign wr_en = access_cyc && pwrite_i && addr_hit && pstrb_i[0];

  // ==========================================================
  // APB slave and register file
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    div_d = div_q;
    src_d = src_q;
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    case (state_q)
      APB_IDLE: begin
        if (setup_cyc) begin
          state_d = APB_ACCESS;
          rdata_d = pwrite_i ? '0 : f_read(paddr_i, ctrl_q, div_q, src_q, div_count);
          slverr_d = !addr_hit;
        end
      end
      APB_ACCESS: begin
        if (!psel_i || penable_i) begin
          state_d = APB_IDLE;
        end
        if (wr_en) begin
          if (paddr_i == ADDR_CTRL) begin
            ctrl_d = wdata8 & CTRL_MASK;
          end else if (paddr_i == ADDR_DIV) begin
            div_d = wdata8;
          end else if (paddr_i == ADDR_SRC) begin
            src_d = wdata8[SRC_BIT];
          end
        end
      end
      default: begin
        state_d = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= APB_IDLE;
      ctrl_q <= CTRL_RST;
      div_q <= DIV_RST;
      src_q <= SRC_RST;
      rdata_q <= '0;
      slverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      div_q <= div_d;
      src_q <= src_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign pready_o = (state_q == APB_ACCESS);
  assign pslverr_o = pready_o && slverr_q;
  assign prdata_o = {{(APB_DW - REG_DW){1'b0}}, rdata_q};

  // ==========================================================
  // Shared divider for channels 0 and 1
  assign sel_tick = src_q ? pll2_tick_i : pll1_tick_i;

  opc_divider u_div (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .tick_i(sel_tick),
    .div_i(div_q),
    .tick_o(div_tick),
    .count_o(div_count)
  );

  // One divider output feeds both channels
  assign ch0_div_tick_o = div_tick;
  assign ch1_div_tick_o = div_tick;
  assign ch01_pll_source_select_o = src_q;

  // ==========================================================
  // Channel-1 driver settings
  assign ch1_format_o = ctrl_q[FMT_HI:FMT_LO];

  opc_drv_decode u_dec (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .fmt_i(ctrl_q[FMT_HI:FMT_LO]),
    .mode_a_i(ctrl_q[MA_HI:MA_LO]),
    .mode_b_i(ctrl_q[MB_HI:MB_LO]),
    .diff_en_o(ch1_diff_en_o),
    .hcsl_en_o(ch1_hcsl_en_o),
    .cmos_en_o(ch1_cmos_en_o),
    .tail_ma_o(ch1_tail_ma_o),
    .load_ohm_o(ch1_load_ohm_o),
    .pin_p_o(pin_p),
    .pin_n_o(pin_n)
  );

  assign {ch1_p_oe_o, ch1_p_active_o, ch1_p_inv_o} = pin_p;
  assign {ch1_n_oe_o, ch1_n_active_o, ch1_n_inv_o} = pin_n;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_setup(logic [APB_AW-1:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a && state_q == APB_IDLE;
  endsequence

  sequence s_wsetup(logic [APB_AW-1:0] a);
    psel_i && !penable_i && pwrite_i && paddr_i == a && state_q == APB_IDLE;
  endsequence

  sequence s_waccess;
    psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0] && $stable(paddr_i);
  endsequence

  property p_reset_values;
    $fell(srst_i) |-> ctrl_q == CTRL_RST && ctrl_q[FMT_HI:FMT_LO] == FMT_DIFF;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("control reset wrong");

  property p_div_reset;
    $fell(srst_i) |-> div_q == DIV_RST && src_q == SRC_RST;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider or source reset wrong");

  property p_ctrl_write;
    s_wsetup(ADDR_CTRL) ##1 s_waccess |=> ctrl_q == ($past(wdata8) & CTRL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("reserved bit stored");

  property p_ctrl_read;
    s_setup(ADDR_CTRL) |=> pready_o && !prdata_o[SRC_BIT] && !prdata_o[0]
                           && prdata_o[FMT_HI:MB_LO] == ctrl_q[FMT_HI:MB_LO];
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bits read as one");

  property p_div_write;
    s_wsetup(ADDR_DIV) ##1 s_waccess |=> div_q == $past(wdata8) ##1 1'b1;
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write lost");

  property p_src_pll2;
    src_q && div_q == DIV_BYPASS && pll2_tick_i |=> ch0_div_tick_o && ch1_div_tick_o;
  endproperty
  a_src_pll2: assert property (p_src_pll2) else $error("second pll not routed");

  property p_src_pll1;
    !src_q && div_q == DIV_BYPASS |=> ch1_div_tick_o == $past(pll1_tick_i);
  endproperty
  a_src_pll1: assert property (p_src_pll1) else $error("first pll not routed");

  property p_unmapped;
    setup_cyc && state_q == APB_IDLE && !addr_hit |=> pready_o && pslverr_o && prdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");

  property p_one_wait;
    setup_cyc && state_q == APB_IDLE |=> pready_o ##1 !pready_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer timing wrong");

  sequence s_regs_hold;
    $stable(ctrl_q) && $stable(div_q) && $stable(src_q);
  endsequence

  property p_idle_hold;
    !access_cyc |=> s_regs_hold;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("register changed outside access");

  property p_read_hold;
    access_cyc && !pwrite_i |=> s_regs_hold;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read changed a register");

  property p_strb_ignored;
    access_cyc && pwrite_i && !pstrb_i[0] |=> s_regs_hold;
  endproperty
  a_strb_ignored: assert property (p_strb_ignored) else $error("write without strobe landed");

  property p_unmapped_write;
    access_cyc && pwrite_i && !addr_hit |=> s_regs_hold;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  property p_stat_ro;
    access_cyc && pwrite_i && paddr_i == ADDR_STAT |=> s_regs_hold;
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("status write landed");

  property p_src_write;
    s_wsetup(ADDR_SRC) ##1 s_waccess |=> src_q == $past(wdata8[SRC_BIT]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source write lost");

  property p_src_read;
    s_setup(ADDR_SRC) |=> prdata_o[SRC_BIT] == src_q && prdata_o[SRC_BIT-1:0] == '0;
  endproperty
  a_src_read: assert property (p_src_read) else $error("source readback wrong");

  property p_div_read;
    s_setup(ADDR_DIV) |=> pready_o && prdata_o[REG_DW-1:0] == div_q;
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider readback wrong");

  property p_stat_read;
    s_setup(ADDR_STAT) |=> prdata_o[REG_DW-1:0] == $past(div_count);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status readback wrong");

  property p_mapped_ok;
    setup_cyc && state_q == APB_IDLE && addr_hit |=> pready_o && !pslverr_o;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped address refused");

  property p_upper_zero;
    pready_o |-> prdata_o[APB_DW-1:REG_DW] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
endmodule // opc_output_pair_regs
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import opc_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [APB_AW-1:0] paddr_i = '0;
  logic [APB_DW-1:0] pwdata_i = '0;
  logic [3:0] pstrb_i = 4'hF;
  logic pll1_tick_i = 1'b0;
  logic pll2_tick_i = 1'b0;
  logic [APB_DW-1:0] prdata_o;
  logic pready_o, pslverr_o, ch0_div_tick_o, ch1_div_tick_o, ch01_pll_source_select_o;
  logic [1:0] ch1_format_o;
  logic ch1_diff_en_o, ch1_hcsl_en_o, ch1_cmos_en_o;
  logic [4:0] ch1_tail_ma_o;
  logic [7:0] ch1_load_ohm_o;
  logic ch1_p_oe_o, ch1_p_active_o, ch1_p_inv_o, ch1_n_oe_o, ch1_n_active_o, ch1_n_inv_o;
  int num_errors = 0;
  int n_compared = 0;
  logic [4:0] tl [4] = '{5'h04, 5'h06, 5'h08, 5'h10};
  logic [7:0] ld [4] = '{8'h00, 8'h32, 8'h64, 8'hC8};
  logic [2:0] pm [4] = '{3'h0, 3'h4, 3'h7, 3'h6};

  always #2 ref_clk_i = ~ref_clk_i;

  opc_output_pair_regs u_opc_output_pair_regs (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pll1_tick_i(pll1_tick_i), .pll2_tick_i(pll2_tick_i),
    .ch0_div_tick_o(ch0_div_tick_o), .ch1_div_tick_o(ch1_div_tick_o),
    .ch01_pll_source_select_o(ch01_pll_source_select_o), .ch1_format_o(ch1_format_o),
    .ch1_diff_en_o(ch1_diff_en_o), .ch1_hcsl_en_o(ch1_hcsl_en_o),
    .ch1_cmos_en_o(ch1_cmos_en_o), .ch1_tail_ma_o(ch1_tail_ma_o),
    .ch1_load_ohm_o(ch1_load_ohm_o), .ch1_p_oe_o(ch1_p_oe_o),
    .ch1_p_active_o(ch1_p_active_o), .ch1_p_inv_o(ch1_p_inv_o), .ch1_n_oe_o(ch1_n_oe_o),
    .ch1_n_active_o(ch1_n_active_o), .ch1_n_inv_o(ch1_n_inv_o)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk(n, 1, "single access cycle");
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
    chk(err, 0, "write error flag");
  endtask

  task automatic rdchk(input logic [APB_AW-1:0] a, input logic [7:0] exp, input string what);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 8'h00, rd, err);
    chk(rd, {24'h0, exp}, what);
    chk(err, 0, "read error flag");
  endtask

  function automatic logic [23:0] outs();
    return {ch1_diff_en_o, ch1_hcsl_en_o, ch1_cmos_en_o, ch1_tail_ma_o, ch1_load_ohm_o,
            ch1_p_oe_o, ch1_p_active_o, ch1_p_inv_o, ch1_n_oe_o, ch1_n_active_o,
            ch1_n_inv_o, ch1_format_o};
  endfunction

  // Gap in cycles between two divided ticks, inputs ticking every cycle
  task automatic spacing(input int exp, input string what);
    int n, gap;
    logic same;
    same = 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      n++;
      same &= (ch0_div_tick_o === ch1_div_tick_o);
    end while (ch1_div_tick_o !== 1'b1 && n < 600);
    gap = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      gap++;
      same &= (ch0_div_tick_o === ch1_div_tick_o);
    end while (ch1_div_tick_o !== 1'b1 && gap < 600);
    chk(gap, exp, what);
    chk(same, 1, "channel 0 and 1 ticks equal");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdchk(ADDR_CTRL, 8'h30, "control reset");
    rdchk(ADDR_DIV, 8'h01, "divider reset");
    rdchk(ADDR_SRC, 8'h80, "source reset");
    chk(ch01_pll_source_select_o, 1, "source output reset");
    chk(outs(), {3'h4, 5'h08, 8'h00, 6'h00, 2'h1}, "decode at reset");
    $display("test reset done");
  endtask

  task automatic t_reserved;
    wr(ADDR_CTRL, 8'hFF);
    rdchk(ADDR_CTRL, 8'h7E, "reserved bits set");
    wr(ADDR_CTRL, 8'h01);
    rdchk(ADDR_CTRL, 8'h00, "reserved bit 0 alone");
    $display("test reserved done");
  endtask

  task automatic t_decode;
    logic [1:0] f, a, b;
    logic [23:0] e;
    for (int i = 0; i < 16; i++) begin
      f = i[3:2];
      a = i[1:0];
      b = a + 2'h1;
      wr(ADDR_CTRL, {1'b0, f, a, b, 1'b0});
      repeat (2) @(posedge ref_clk_i);
      #1;
      e = {f == 2'h1, f == 2'h2, f == 2'h3, (f == 2'h1 || f == 2'h2) ? tl[a] : 5'h00,
           f == 2'h2 ? ld[b] : 8'h00, f == 2'h3 ? pm[a] : 3'h0, f == 2'h3 ? pm[b] : 3'h0, f};
      chk(outs(), e, "driver decode");
      rdchk(ADDR_CTRL, {1'b0, f, a, b, 1'b0}, "control readback");
    end
    $display("test decode done");
  endtask

  task automatic t_unmapped;
    logic [31:0] rd;
    logic err;
    apb(1'b0, 12'h100, 8'h00, rd, err);
    chk(err, 1, "unmapped read error");
    chk(rd, 0, "unmapped read data");
    apb(1'b1, 12'h100, 8'h55, rd, err);
    chk(err, 1, "unmapped write error");
    wr(ADDR_STAT, 8'hAA);
    rdchk(ADDR_STAT, 8'h00, "status ignores writes");
    pstrb_i <= 4'h0;
    wr(ADDR_DIV, 8'h55);
    pstrb_i <= 4'hF;
    rdchk(ADDR_DIV, DIV_RST, "write without strobe ignored");
    $display("test unmapped done");
  endtask

  task automatic t_div;
    logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    pll2_tick_i <= 1'b1;
    foreach (codes[k]) begin
      wr(ADDR_DIV, codes[k]);
      rdchk(ADDR_DIV, codes[k], "divider readback");
      spacing(int'(codes[k]) == 0 ? 1 : int'(codes[k]) + 1, "divided tick gap");
    end
    $display("test divider done");
  endtask

  task automatic t_src;
    int cnt;
    wr(ADDR_DIV, 8'h01);
    wr(ADDR_SRC, 8'h00);
    rdchk(ADDR_SRC, 8'h00, "source cleared");
    chk(ch01_pll_source_select_o, 0, "source output cleared");
    pll1_tick_i <= 1'b0;
    pll2_tick_i <= 1'b1;
    cnt = 0;
    repeat (3) @(posedge ref_clk_i);
    repeat (20) begin
      @(posedge ref_clk_i);
      #1;
      cnt += ch1_div_tick_o;
    end
    chk(cnt, 0, "second pll ignored");
    pll1_tick_i <= 1'b1;
    pll2_tick_i <= 1'b0;
    spacing(2, "first pll divided");
    wr(ADDR_DIV, 8'h00);
    spacing(1, "first pll bypassed");
    wr(ADDR_SRC, 8'h80);
    rdchk(ADDR_SRC, 8'h80, "source restored");
    $display("test source done");
  endtask

  // ==========================================================
  // Run control
  task automatic summarize;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_reserved();
    t_decode();
    t_unmapped();
    t_div();
    t_src();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
